// *** logic/sadc_top.v ***
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/100ps
`include "sadc_map.vh"

module sadc_top #(
  parameter STEP_FAST = `SADC_STEP_FAST,
  parameter STEP_SLOW = `SADC_STEP_SLOW
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [9:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // analog front end
  input  wire        cmp_i,
  input  wire [3:0]  pin_i,
  output reg  [1:0]  ch_sel_o,
  output reg  [9:0]  dac_code_o,
  output reg         sample_o,
  // interrupt request
  output reg         conv_irq_o
);

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam ST_IDLE   = 3'b001;
  localparam ST_LAUNCH = 3'b010;
  localparam ST_CONV   = 3'b100;

  reg  [2:0]  state;
  reg  [2:0]  next_state;

  // mode register
  reg  [1:0]  channel_select;
  reg         scan_bit;
  reg         repeat_bit;
  reg         speed_select;
  reg         busy_flag;
  reg         end_flag;

  // results and channel
  reg  [9:0]  result [0:3];
  reg  [1:0]  cur_ch;
  reg  [1:0]  next_ch;
  reg         sar_start;

  // synchronisers
  reg         cmp_meta;
  reg         cmp_sync;
  reg  [3:0]  pin_meta;
  reg  [3:0]  pin_sync;

  // sar engine
  wire [9:0]  sar_code;
  wire [9:0]  sar_result;
  wire        sar_done;

  // bus decode
  wire        bus_req;
  wire        bus_wr;
  wire        bus_rd;
  wire [7:0]  idx;
  wire        mode_wr;
  wire        start_req;
  wire        res_read;
  reg  [7:0]  rd_byte;

  // end of sequence decisions
  reg         seq_more;
  reg         seq_again;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // channels in analog use for the current configuration
  function [3:0] analog_mask;
    input [1:0] sel;
    input       scan;
    begin
      case (sel)
        2'd0:    analog_mask = scan ? 4'b0001 : 4'b0001;
        2'd1:    analog_mask = scan ? 4'b0011 : 4'b0010;
        2'd2:    analog_mask = scan ? 4'b0111 : 4'b0100;
        default: analog_mask = scan ? 4'b1111 : 4'b1000;
      endcase
    end
  endfunction

  // low result byte: two lsbs on top, ones below
  function [7:0] low_byte;
    input [9:0] res;
    begin
      low_byte = {res[1:0], `SADC_LOW_FILL};
    end
  endfunction

  // high result byte: the eight msbs
  function [7:0] high_byte;
    input [9:0] res;
    begin
      high_byte = res[9:2];
    end
  endfunction

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end
    else
    begin
      cmp_meta <= cmp_i;
      cmp_sync <= cmp_meta;
      pin_meta <= pin_i;
      pin_sync <= pin_meta;
    end
  end

  // ------------------------------------------------------------
  // wishbone decode
  // ------------------------------------------------------------
  assign bus_req = cyc_i && stb_i && !ack_o;
  assign bus_wr = bus_req && we_i && sel_i[0];
  assign bus_rd = bus_req && !we_i;
  assign idx = adr_i[9:2];
  assign mode_wr = bus_wr && (idx == `SADC_IDX_MODE);
  // RULE5 start on write
  assign start_req = mode_wr && dat_i[`SADC_MODE_START]
                     && (state == ST_IDLE);
  // RULE12 result read side effect
  assign res_read = bus_rd && (idx >= `SADC_IDX_CH0_LOW) && (idx <= `SADC_IDX_CH3_HIGH);

  always @*
  begin
    rd_byte = 8'h00;
    case (idx)
      // RULE13 low byte layout
      `SADC_IDX_CH0_LOW:  rd_byte = low_byte(result[0]);
      `SADC_IDX_CH1_LOW:  rd_byte = low_byte(result[1]);
      `SADC_IDX_CH2_LOW:  rd_byte = low_byte(result[2]);
      `SADC_IDX_CH3_LOW:  rd_byte = low_byte(result[3]);
      // RULE14 high byte layout
      `SADC_IDX_CH0_HIGH: rd_byte = high_byte(result[0]);
      `SADC_IDX_CH1_HIGH: rd_byte = high_byte(result[1]);
      `SADC_IDX_CH2_HIGH: rd_byte = high_byte(result[2]);
      `SADC_IDX_CH3_HIGH: rd_byte = high_byte(result[3]);
      `SADC_IDX_MODE:     rd_byte = {end_flag, busy_flag, 1'b0, speed_select,
                                     repeat_bit, scan_bit, channel_select};
      // RULE16 unused pins as port
      `SADC_IDX_PORT:     rd_byte = {4'h0, pin_sync & ~analog_mask(channel_select, scan_bit)};
      default:            rd_byte = 8'h00;
    endcase
  end

  // one wait state, unmapped reads return zero
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= bus_req;
      if (bus_rd)
        dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // ------------------------------------------------------------
  // mode register
  // ------------------------------------------------------------
  // RULE15 results take no writes
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // RULE4 channel zero
      channel_select <= `SADC_RST_CH;
      // RULE7 high speed default
      speed_select <= `SADC_RST_SPEED;
      scan_bit <= 1'b0;
      repeat_bit <= 1'b0;
    end
    else if (mode_wr)
    begin
      channel_select <= dat_i[`SADC_MODE_CH_HI:`SADC_MODE_CH_LO];
      scan_bit <= dat_i[`SADC_MODE_SCAN];
      repeat_bit <= dat_i[`SADC_MODE_REPEAT];
      speed_select <= dat_i[`SADC_MODE_SPEED];
    end
  end

  // ------------------------------------------------------------
  // sequence decisions
  // ------------------------------------------------------------
  always @*
  begin
    // RULE3 ascending scan
    seq_more = scan_bit && (cur_ch != channel_select);
    // RULE10 repeat checked at end
    seq_again = repeat_bit;
    next_ch = cur_ch;
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (start_req)
        begin
          // RULE2 fixed channel
          next_ch = dat_i[`SADC_MODE_SCAN] ? 2'd0
                    : dat_i[`SADC_MODE_CH_HI:`SADC_MODE_CH_LO];
          next_state = ST_LAUNCH;
        end
      end
      ST_LAUNCH:
        next_state = ST_CONV;
      ST_CONV:
      begin
        if (sar_done)
        begin
          if (seq_more)
          begin
            // RULE18 auto advance
            next_ch = cur_ch + 2'd1;
            next_state = ST_LAUNCH;
          end
          else if (seq_again)
          begin
            // RULE6 repeat restarts
            next_ch = scan_bit ? 2'd0 : channel_select;
            next_state = ST_LAUNCH;
          end
          else
            next_state = ST_IDLE;
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      cur_ch <= 2'd0;
      sar_start <= 1'b0;
      busy_flag <= 1'b0;
      end_flag <= 1'b0;
      conv_irq_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cur_ch <= next_ch;
      sar_start <= (next_state == ST_LAUNCH);
      conv_irq_o <= 1'b0;
      if (start_req)
        // RULE5 busy while converting
        busy_flag <= 1'b1;
      if ((state == ST_CONV) && sar_done && !seq_more && !seq_again)
      begin
        // RULE8 single end
        busy_flag <= 1'b0;
        end_flag <= 1'b1;
        conv_irq_o <= 1'b1;
      end
      else if (res_read)
        end_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // result storage
  // ------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      result[0] <= 10'h000;
      result[1] <= 10'h000;
      result[2] <= 10'h000;
      result[3] <= 10'h000;
    end
    // RULE11 overwrite per channel
    else if ((state == ST_CONV) && sar_done)
      result[cur_ch] <= sar_result;
  end

  // ------------------------------------------------------------
  // analog front end drive
  // ------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ch_sel_o <= 2'd0;
      dac_code_o <= 10'h000;
      sample_o <= 1'b0;
    end
    else
    begin
      ch_sel_o <= cur_ch;
      dac_code_o <= sar_code;
      sample_o <= (state == ST_CONV);
    end
  end

  sadc_sar #(
    .STEP_FAST (STEP_FAST),
    .STEP_SLOW (STEP_SLOW)
  ) u_sar (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .start_i  (sar_start),
    .speed_i  (speed_select),
    .cmp_i    (cmp_sync),
    .code_o   (sar_code),
    .result_o (sar_result),
    .done_o   (sar_done)
  );

endmodule

// *** logic/sadc_map.vh ***
// Notes on behaviour
// RULE1 - four inputs, 10-bit successive approximation result
// RULE2 - fixed mode converts only selected channel
// RULE3 - scan converts channels zero up to select
// RULE4 - reset clears channel select to zero
// RULE5 - start bit begins conversion, sets busy
// RULE6 - single or repeat, fixed or scan
// RULE7 - speed select, reset picks high speed
// RULE8 - single end sets end, clears busy, interrupts
// RULE9 - software masks interrupt during repeat mode
// RULE10 - repeat ends after current conversion completes
// RULE11 - per-channel result, overwritten on each end
// RULE12 - any result read clears end flag
// RULE13 - low byte: two LSBs high, ones below
// RULE14 - high byte holds result bits nine..two
// RULE15 - result registers are read only
// RULE16 - unused analog pins readable as port
// RULE17 - ten decisions, MSB first, speed sets step
// RULE18 - scan advances channel without software help
`ifndef SADC_MAP_VH
`define SADC_MAP_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SADC_IDX_CH0_LOW   8'h60
`define SADC_IDX_CH0_HIGH  8'h61
`define SADC_IDX_CH1_LOW   8'h62
`define SADC_IDX_CH1_HIGH  8'h63
`define SADC_IDX_CH2_LOW   8'h64
`define SADC_IDX_CH2_HIGH  8'h65
`define SADC_IDX_CH3_LOW   8'h66
`define SADC_IDX_CH3_HIGH  8'h67
`define SADC_IDX_MODE      8'h68
`define SADC_IDX_PORT      8'h69

// ----------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------
`define SADC_MODE_CH_LO    0
`define SADC_MODE_CH_HI    1
`define SADC_MODE_SCAN     2
`define SADC_MODE_REPEAT   3
`define SADC_MODE_SPEED    4
`define SADC_MODE_START    5
`define SADC_MODE_BUSY     6
`define SADC_MODE_END      7

// ----------------------------------------------------------------
// reset values and result layout
// ----------------------------------------------------------------
`define SADC_RST_CH        2'b00
`define SADC_RST_SPEED     1'b0
`define SADC_LOW_FILL      6'h3f
`define SADC_RES_MSB       10'h200
`define SADC_RES_LSB       10'h001

// ----------------------------------------------------------------
// step timing in clock cycles per comparator decision
// ----------------------------------------------------------------
`define SADC_STEP_FAST     16
`define SADC_STEP_SLOW     32

`endif

// *** logic/sadc_sar.v ***
`timescale 1ns/100ps
`include "sadc_map.vh"

module sadc_sar #(
  parameter STEP_FAST = `SADC_STEP_FAST,
  parameter STEP_SLOW = `SADC_STEP_SLOW
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // control
  input  wire        start_i,
  input  wire        speed_i,
  input  wire        cmp_i,
  // results
  output reg  [9:0]  code_o,
  output reg  [9:0]  result_o,
  output reg         done_o
);

  reg  [9:0]  mask;
  reg         running;
  reg  [7:0]  step_cnt;
  wire [7:0]  step_last;
  wire        step_tick;
  wire [9:0]  kept;

  // ------------------------------------------------------------
  // step divider
  // ------------------------------------------------------------
  // RULE17 speed sets step
  assign step_last = speed_i ? (STEP_SLOW[7:0] - 8'h01) : (STEP_FAST[7:0] - 8'h01);
  assign step_tick = running && (step_cnt == step_last);

  always @(posedge clk_i)
  begin
    if (rst_i || start_i || step_tick)
      step_cnt <= 8'h00;
    else if (running)
      step_cnt <= step_cnt + 8'h01;
  end

  // ------------------------------------------------------------
  // approximation register
  // ------------------------------------------------------------
  // comparator high means the input lies at or above the trial level
  assign kept = cmp_i ? code_o : (code_o & ~mask);

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      code_o   <= 10'h000;
      result_o <= 10'h000;
      mask     <= 10'h000;
      running  <= 1'b0;
      done_o   <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i)
      begin
        // RULE17 msb trial first
        code_o  <= `SADC_RES_MSB;
        mask    <= `SADC_RES_MSB;
        running <= 1'b1;
      end
      else if (step_tick)
      begin
        // RULE1 ten bit decisions
        if (mask == `SADC_RES_LSB)
        begin
          code_o   <= kept;
          result_o <= kept;
          running  <= 1'b0;
          done_o   <= 1'b1;
        end
        else
        begin
          code_o <= kept | (mask >> 1);
          mask   <= mask >> 1;
        end
      end
    end
  end

endmodule

// *** verification/sadc_ladder.sv ***
`timescale 1ns/100ps
module sadc_ladder (
  // mux, ladder and comparator
  input  wire [1:0]  ch_sel_i,
  input  wire [9:0]  dac_code_i,
  input  wire [39:0] level_i,
  output wire        cmp_o
);
  // high keeps the trial bit: input at or above the trial level
  assign cmp_o = level_i[ch_sel_i*10 +: 10] >= dac_code_i;
endmodule

// *** verification/sadc_chk_asserts.sv ***
`timescale 1ns/100ps
module sadc_chk (
  // bus side of the top module
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [9:0]  adr_i,
  input  wire [31:0] dat_o,
  input  wire        ack_o,
  input  wire        conv_irq_o,
  // analog side of the top module
  input  wire        sample_o,
  input  wire [1:0]  ch_sel_o,
  input  wire [9:0]  dac_code_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_rd(idx);
    cyc_i && stb_i && !ack_o && !we_i && adr_i[9:2] == idx;
  endsequence
  sequence s_rd_low;
    cyc_i && stb_i && !ack_o && !we_i && adr_i[9:6] == 4'h6 && !adr_i[5] && !adr_i[2];
  endsequence
  sequence s_end_tail;
    sample_o ##1 !sample_o;
  endsequence
  property p_ack_resp;
    s_take |=> ack_o;
  endproperty
  property p_ack_cause;
    !(cyc_i && stb_i) |=> !ack_o;
  endproperty
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  property p_irq_pulse;
    conv_irq_o |=> !conv_irq_o;
  endproperty
  property p_low_fill;
    s_rd_low |=> dat_o[5:0] == 6'h3f;
  endproperty
  property p_hi_zero;
    ack_o |-> dat_o[31:8] == 24'h0;
  endproperty
  property p_port;
    s_rd(8'h69) |=> dat_o[7:4] == 4'h0;
  endproperty
  property p_unmapped;
    s_rd(8'h40) |=> dat_o == 32'h0;
  endproperty
  property p_start0;
    s_rd(8'h68) |=> !dat_o[5];
  endproperty
  property p_end_sample;
    conv_irq_o |-> s_end_tail;
  endproperty
  property p_msb_first;
    $rose(sample_o) |-> dac_code_o == 10'h200;
  endproperty
  property p_ch_hold;
    sample_o && $past(sample_o) |-> $stable(ch_sel_o);
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
  a_low_fill: assert property (p_low_fill) else $error("low byte fill wrong");
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
  a_port: assert property (p_port) else $error("port upper bits set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  a_start0: assert property (p_start0) else $error("start bit reads one");
  a_end_sample: assert property (p_end_sample) else $error("irq not at conversion end");
  a_msb_first: assert property (p_msb_first) else $error("first trial not msb");
  a_ch_hold: assert property (p_ch_hold) else $error("channel moved mid conversion");
endmodule

bind sadc_top sadc_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .conv_irq_o(conv_irq_o),
  .sample_o(sample_o), .ch_sel_o(ch_sel_o), .dac_code_o(dac_code_o));

// *** verification/tb.sv ***
`timescale 1ns/100ps
module tb;
  reg         clk_i, rst_i, cyc_i, stb_i, we_i;
  reg  [9:0]  adr_i;
  reg  [3:0]  sel_i, pin_i;
  reg  [31:0] dat_i;
  reg  [39:0] level;
  reg  [7:0]  q;
  wire [31:0] dat_o;
  wire        ack_o, cmp, sample_o, conv_irq_o;
  wire [1:0]  ch_sel_o;
  wire [9:0]  dac_code_o;
  integer     n_fail, comparisons, i, irqs;
  localparam CONV = 48;
  sadc_top #(.STEP_FAST(4), .STEP_SLOW(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .cmp_i(cmp), .pin_i(pin_i), .ch_sel_o(ch_sel_o),
    .dac_code_o(dac_code_o), .sample_o(sample_o), .conv_irq_o(conv_irq_o));
  sadc_ladder ladder_u (.ch_sel_i(ch_sel_o), .dac_code_i(dac_code_o), .level_i(level),
    .cmp_o(cmp));
  initial
  begin
    clk_i = 0;
    forever #4 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // bus, compare and closing tasks
  // ----------------------------------------
  task close_out;
  begin
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task chk8(input [7:0] got, input [7:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task wb(input w, input [7:0] idx, input [7:0] d);
  begin
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1)
      @(posedge clk_i);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  end
  endtask
  task rd_chk(input [7:0] idx, input [7:0] exp);
  begin
    wb(1'b0, idx, 8'h00);
    chk8(q, exp);
  end
  endtask
  task wait_irq(input integer n);
  begin
    i = 0;
    irqs = 0;
    while (irqs == 0 && i < n)
    begin
      @(posedge clk_i);
      i = i + 1;
      if (conv_irq_o === 1'b1)
        irqs = 1;
    end
  end
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    n_fail = 0;
    comparisons = 0;
    rst_i = 1;
    {cyc_i, stb_i, we_i} = 3'b000;
    adr_i = 0;
    dat_i = 0;
    sel_i = 4'h1;
    pin_i = 4'hf;
    level = {10'h2a5, 10'h0f0, 10'h3ff, 10'h001};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(8'h68, 8'h00);
    rd_chk(8'h40, 8'h00);
    wb(1'b1, 8'h68, 8'h23);
    rd_chk(8'h68, 8'h43);
    wait_irq(CONV);
    chk8(irqs, 1);
    chk8({7'h0, i < 45}, 8'h01);
    rd_chk(8'h68, 8'h83);
    rd_chk(8'h66, 8'h7f);
    rd_chk(8'h68, 8'h03);
    rd_chk(8'h67, 8'ha9);
    rd_chk(8'h61, 8'h00);
    wb(1'b1, 8'h67, 8'h00);
    rd_chk(8'h67, 8'ha9);
    // a write without its byte lane selected must not start anything
    sel_i <= 4'h0;
    wb(1'b1, 8'h68, 8'h36);
    sel_i <= 4'h1;
    rd_chk(8'h68, 8'h03);
    wb(1'b1, 8'h68, 8'h36);
    wait_irq(6 * CONV);
    chk8(irqs, 1);
    chk8({7'h0, i > 200}, 8'h01);
    rd_chk(8'h60, 8'h7f);
    rd_chk(8'h63, 8'hff);
    rd_chk(8'h65, 8'h3c);
    rd_chk(8'h67, 8'ha9);
    rd_chk(8'h69, 8'h08);
    // software keeps the interrupt unused while repeating
    wb(1'b1, 8'h68, 8'h29);
    wait_irq(2 * CONV);
    chk8(irqs, 0);
    level[19:10] <= 10'h155;
    wait_irq(2 * CONV);
    chk8(irqs, 0);
    rd_chk(8'h63, 8'h55);
    wb(1'b1, 8'h68, 8'h01);
    rd_chk(8'h68, 8'h41);
    wait_irq(CONV);
    chk8(irqs, 1);
    rd_chk(8'h62, 8'h7f);
    wb(1'b1, 8'h68, 8'h2d);
    wait_irq(3 * CONV);
    chk8(irqs, 0);
    wb(1'b1, 8'h68, 8'h05);
    wait_irq(3 * CONV);
    chk8(irqs, 1);
    close_out;
  end
  initial
  begin
    #(8 * 5000);
    n_fail = n_fail + 1;
    close_out;
  end
endmodule
